// ### src/mrsl_pkg.sv
// constants, types and register map of the modbus rtu station link
// Operation
// - station address 1..247, only own frames answered
// - address zero is broadcast, acted upon but never answered
// - six bit rates, code 1 after reset
// - formats 0..2: none/even/odd parity, one stop
// - formats 3..5: none/even/odd parity, two stops
// - parity generated and checked, even or odd
// - fault when valid frames stop beyond timeout
// - timeout zero disables; also in peer mode
// - reply delay 1..20 ms, default 2
// - reply starts after delay from frame end
// - nonvolatile write lengthens the reply wait
// - only frames with good checks count
// - peer mode enable bit, off at reset
// - leader broadcasts variable every send period
// - leader variable select code, default 1
// - follower scale 0.00..10.00, default 1.00
// - follower applies received value times scale
package mrsl_pkg;
	localparam int          CLK_HZ_DEF  = 25_000_000;
	localparam int          MS_PER_S    = 1000;
	localparam int          MS_PER_TENTH = 100;
	localparam int          DIV_W       = 16;
	localparam int          BAUD_0      = 4800;
	localparam int          BAUD_1      = 9600;
	localparam int          BAUD_2      = 19200;
	localparam int          BAUD_3      = 38400;
	localparam int          BAUD_4      = 57600;
	localparam int          BAUD_5      = 115200;
	localparam logic [7:0]  ADDR_STATION = 8'h00;
	localparam logic [7:0]  ADDR_BAUD    = 8'h04;
	localparam logic [7:0]  ADDR_FMT     = 8'h08;
	localparam logic [7:0]  ADDR_TMO     = 8'h0C;
	localparam logic [7:0]  ADDR_DELAY   = 8'h10;
	localparam logic [7:0]  ADDR_PEER_EN = 8'h14;
	localparam logic [7:0]  ADDR_ROLE    = 8'h18;
	localparam logic [7:0]  ADDR_VAR     = 8'h1C;
	localparam logic [7:0]  ADDR_SCALE   = 8'h20;
	localparam logic [7:0]  ADDR_PERIOD  = 8'h24;
	localparam logic [7:0]  ADDR_STATUS  = 8'h28;
	localparam logic [15:0] RST_STATION = 16'h0001;
	localparam logic [15:0] RST_BAUD    = 16'h0001;
	localparam logic [15:0] RST_FMT     = 16'h0000;
	localparam logic [15:0] RST_TMO     = 16'h0000;
	localparam logic [15:0] RST_DELAY   = 16'h0002;
	localparam logic [15:0] RST_VAR     = 16'h0001;
	localparam logic [15:0] RST_SCALE   = 16'h0064;
	localparam logic [15:0] RST_PERIOD  = 16'h00C8;
	localparam logic [15:0] STATION_MIN = 16'h0001;
	localparam logic [15:0] STATION_MAX = 16'h00F7;
	localparam logic [15:0] CODE_MAX    = 16'h0005;
	localparam logic [15:0] TMO_MAX     = 16'h0258;
	localparam logic [15:0] DELAY_MIN   = 16'h0001;
	localparam logic [15:0] DELAY_MAX   = 16'h0014;
	localparam logic [15:0] SCALE_MAX   = 16'h03E8;
	localparam logic [15:0] PERIOD_MAX  = 16'h7530;
	localparam logic [31:0] SCALE_UNITY = 32'h0000_0064;
	localparam logic [7:0]  BCAST_ADDR  = 8'h00;
	localparam logic [15:0] CRC_INIT    = 16'hFFFF;
	localparam logic [15:0] CRC_POLY    = 16'hA001;
	localparam logic [5:0]  GAP_BITS    = 6'h27;
	localparam logic [7:0]  MIN_BYTES   = 8'h04;
	localparam logic [2:0]  LAST_BIT    = 3'h7;
	localparam logic [2:0]  FMT_TWO_STOP = 3'h3;
	localparam int          ST_FAULT    = 0;
	localparam int          ST_REPLY    = 1;
	localparam int          ST_TX_OPEN  = 2;

	typedef struct packed {
		logic [7:0]  station;
		logic [2:0]  baud;
		logic [2:0]  fmt;
		logic [15:0] tmo;
		logic [4:0]  delay;
		logic        peer_en;
		logic        leader;
		logic [2:0]  var_sel;
		logic [15:0] scale;
		logic [15:0] period;
	} mrsl_cfg_t;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} mrsl_rx_st_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} mrsl_tx_st_t;
	typedef enum logic [1:0] {RP_IDLE, RP_NVM, RP_DELAY} mrsl_rp_st_t;
endpackage : mrsl_pkg

// ### src/mrsl_top.sv
// modbus rtu station link: apb registers, serial line, framing, reply timing, peer mode
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module mrsl_top import mrsl_pkg::*; #(
	parameter int CLK_HZ    = CLK_HZ_DEF,
	parameter int MS_CYCLES = CLK_HZ_DEF / MS_PER_S
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	output logic             txd,
	output logic             tx_drive,
	output logic      [7:0]  rx_byte,
	output logic             rx_byte_stb,
	output logic             frame_valid,
	output logic             frame_bcast,
	input  wire logic        req_format_ok,
	input  wire logic        nvm_busy,
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	input  wire logic        tx_last,
	output logic             tx_ready,
	output logic             peer_send_req,
	output logic      [2:0]  peer_var_sel,
	input  wire logic [15:0] peer_rx_value,
	input  wire logic        peer_rx_stb,
	output logic      [15:0] peer_applied,
	output logic             comm_fault
);
	localparam logic [DIV_W-1:0] MS_LAST = DIV_W'(MS_CYCLES - 1);

	mrsl_cfg_t         cfg_r;
	logic [31:0]       prdata_r;
	logic              pready_r, pslverr_r;
	logic              rxd_s1, rxd_s2, rxd_s3, rx_line_r;
	mrsl_rx_st_t       rx_st_r;
	logic [DIV_W-1:0]  rx_cnt_r, gap_cnt_r;
	logic [5:0]        gap_bits_r;
	logic [2:0]        rx_bit_r;
	logic [7:0]        rx_sh_r, rx_byte_r, rx_count_r, rx_addr_r;
	logic              rx_stb_r, frame_err_r;
	logic [15:0]       crc_r;
	logic              frame_valid_r, frame_bcast_r, frame_end;
	mrsl_rp_st_t       rp_st_r;
	logic [DIV_W-1:0]  rp_cyc_r;
	logic [4:0]        rp_ms_r;
	logic              tx_open_r, tx_ready_r, tx_drive_r, txd_r;
	mrsl_tx_st_t       tx_st_r;
	logic [DIV_W-1:0]  tx_cnt_r;
	logic [2:0]        tx_bit_r;
	logic              tx_stop2_r, tx_last_r;
	logic [7:0]        tx_sh_r;
	logic [DIV_W-1:0]  ms_cnt_r;
	logic              ms_tick;
	logic [6:0]        to_ms_r;
	logic [15:0]       to_tenths_r, per_ms_r;
	logic              fault_r, peer_req_r;
	logic [15:0]       applied_r;
	logic [DIV_W-1:0]  div;
	logic              wr_en, rd_en, addr_ok, tx_take, reply_go, leader_go;
	logic [15:0]       wv;
	logic [31:0]       prod;

	function automatic logic [DIV_W-1:0] bit_div(input logic [2:0] code);
		case (code)
			3'h0:    bit_div = DIV_W'(CLK_HZ / BAUD_0);
			3'h1:    bit_div = DIV_W'(CLK_HZ / BAUD_1);
			3'h2:    bit_div = DIV_W'(CLK_HZ / BAUD_2);
			3'h3:    bit_div = DIV_W'(CLK_HZ / BAUD_3);
			3'h4:    bit_div = DIV_W'(CLK_HZ / BAUD_4);
			default: bit_div = DIV_W'(CLK_HZ / BAUD_5);
		endcase
	endfunction : bit_div

	// parity kind: 0 none, 1 even, 2 odd; same for both stop-bit groups
	function automatic logic [1:0] par_kind(input logic [2:0] fmt);
		case (fmt)
			3'h1, 3'h4: par_kind = 2'h1;
			3'h2, 3'h5: par_kind = 2'h2;
			default:    par_kind = 2'h0;
		endcase
	endfunction : par_kind

	function automatic logic par_bit(input logic [2:0] fmt, input logic [7:0] d);
		par_bit = (par_kind(fmt) == 2'h2) ? ~^d : ^d;
	endfunction : par_bit

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] x;
		x = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		crc_step = x;
	endfunction : crc_step

	assign div     = bit_div(cfg_r.baud);
	assign wr_en   = psel & penable & pready_r & pwrite;
	assign rd_en   = psel & ~penable;
	assign wv      = pwdata[15:0];
	assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= ADDR_STATUS);

	// apb: setup cycle latches read data, access phase always completes in one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= rd_en;
			pslverr_r <= rd_en & ~addr_ok;
			if (rd_en) begin
				case (paddr)
					ADDR_STATION: prdata_r <= {24'h000000, cfg_r.station};
					ADDR_BAUD:    prdata_r <= {29'h0, cfg_r.baud};
					ADDR_FMT:     prdata_r <= {29'h0, cfg_r.fmt};
					ADDR_TMO:     prdata_r <= {16'h0000, cfg_r.tmo};
					ADDR_DELAY:   prdata_r <= {27'h0, cfg_r.delay};
					ADDR_PEER_EN: prdata_r <= {31'h0, cfg_r.peer_en};
					ADDR_ROLE:    prdata_r <= {31'h0, cfg_r.leader};
					ADDR_VAR:     prdata_r <= {29'h0, cfg_r.var_sel};
					ADDR_SCALE:   prdata_r <= {16'h0000, cfg_r.scale};
					ADDR_PERIOD:  prdata_r <= {16'h0000, cfg_r.period};
					ADDR_STATUS:  prdata_r <= {29'h0, tx_open_r, rp_st_r != RP_IDLE, fault_r};
					default:      prdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// out-of-range writes are ignored so the settings never leave their legal sets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r.station <= RST_STATION[7:0];
			cfg_r.baud    <= RST_BAUD[2:0];
			cfg_r.fmt     <= RST_FMT[2:0];
			cfg_r.tmo     <= RST_TMO;
			cfg_r.delay   <= RST_DELAY[4:0];
			cfg_r.peer_en <= 1'b0;
			cfg_r.leader  <= 1'b0;
			cfg_r.var_sel <= RST_VAR[2:0];
			cfg_r.scale   <= RST_SCALE;
			cfg_r.period  <= RST_PERIOD;
		end else if (wr_en) begin
			case (paddr)
				ADDR_STATION: if (wv >= STATION_MIN && wv <= STATION_MAX) cfg_r.station <= wv[7:0];
				ADDR_BAUD:    if (wv <= CODE_MAX) cfg_r.baud <= wv[2:0];
				ADDR_FMT:     if (wv <= CODE_MAX) cfg_r.fmt <= wv[2:0];
				ADDR_TMO:     if (wv <= TMO_MAX) cfg_r.tmo <= wv;
				ADDR_DELAY:   if (wv >= DELAY_MIN && wv <= DELAY_MAX) cfg_r.delay <= wv[4:0];
				ADDR_PEER_EN: cfg_r.peer_en <= wv[0];
				ADDR_ROLE:    cfg_r.leader <= wv[0];
				ADDR_VAR:     if (wv <= CODE_MAX) cfg_r.var_sel <= wv[2:0];
				ADDR_SCALE:   if (wv <= SCALE_MAX) cfg_r.scale <= wv;
				ADDR_PERIOD:  if (wv <= PERIOD_MAX) cfg_r.period <= wv;
				default:      cfg_r <= cfg_r;
			endcase
		end
	end

	// line input: a level change counts once the last two stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_s1    <= 1'b1;
			rxd_s2    <= 1'b1;
			rxd_s3    <= 1'b1;
			rx_line_r <= 1'b1;
		end else begin
			rxd_s1 <= rxd;
			rxd_s2 <= rxd_s1;
			rxd_s3 <= rxd_s2;
			if (rxd_s2 == rxd_s3) rx_line_r <= rxd_s3;
		end
	end

	// receiver samples mid-bit; only one stop bit is checked, a second just looks idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_r  <= RX_IDLE;
			rx_cnt_r <= '0;
			rx_bit_r <= 3'h0;
			rx_sh_r  <= 8'h00;
			rx_byte_r <= 8'h00;
			rx_stb_r <= 1'b0;
		end else begin
			rx_stb_r <= 1'b0;
			if (rx_st_r != RX_IDLE && rx_cnt_r != '0) rx_cnt_r <= rx_cnt_r - 1'b1;
			case (rx_st_r)
				RX_IDLE: if (!rx_line_r) begin
					rx_st_r  <= RX_START;
					rx_cnt_r <= div >> 1;
				end
				RX_START: if (rx_cnt_r == '0) begin
					rx_st_r  <= rx_line_r ? RX_IDLE : RX_DATA;
					// the zero cycle belongs to the bit, so reload one less or drift a cycle per bit
					rx_cnt_r <= div - 1'b1;
					rx_bit_r <= 3'h0;
				end
				RX_DATA: if (rx_cnt_r == '0) begin
					rx_sh_r  <= {rx_line_r, rx_sh_r[7:1]};
					rx_bit_r <= rx_bit_r + 1'b1;
					rx_cnt_r <= div - 1'b1;
					if (rx_bit_r == LAST_BIT)
						rx_st_r <= (par_kind(cfg_r.fmt) != 2'h0) ? RX_PAR : RX_STOP;
				end
				RX_PAR: if (rx_cnt_r == '0) begin
					rx_st_r  <= RX_STOP;
					rx_cnt_r <= div - 1'b1;
				end
				RX_STOP: if (rx_cnt_r == '0) begin
					rx_st_r   <= RX_IDLE;
					rx_byte_r <= rx_sh_r;
					rx_stb_r  <= 1'b1;
				end
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	// frame bookkeeping: parity, framing, crc residue, byte count and silence gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_err_r <= 1'b0;
			crc_r       <= CRC_INIT;
			rx_count_r  <= 8'h00;
			rx_addr_r   <= 8'h00;
			gap_cnt_r   <= '0;
			gap_bits_r  <= 6'h0;
		end else begin
			if (rx_st_r == RX_PAR && rx_cnt_r == '0 && rx_line_r != par_bit(cfg_r.fmt, rx_sh_r))
				frame_err_r <= 1'b1;
			if (rx_st_r == RX_STOP && rx_cnt_r == '0 && !rx_line_r)
				frame_err_r <= 1'b1;
			if (rx_stb_r) begin
				crc_r <= crc_step(crc_r, rx_byte_r);
				if (rx_count_r == 8'h00) rx_addr_r <= rx_byte_r;
				if (rx_count_r != 8'hFF) rx_count_r <= rx_count_r + 1'b1;
			end
			if (rx_st_r != RX_IDLE || rx_count_r == 8'h00) begin
				gap_cnt_r  <= '0;
				gap_bits_r <= 6'h0;
			end else if (frame_end) begin
				frame_err_r <= 1'b0;
				crc_r       <= CRC_INIT;
				rx_count_r  <= 8'h00;
			end else if (gap_cnt_r >= div) begin
				gap_cnt_r  <= '0;
				gap_bits_r <= gap_bits_r + 1'b1;
			end else begin
				gap_cnt_r <= gap_cnt_r + 1'b1;
			end
		end
	end

	assign frame_end = (rx_st_r == RX_IDLE) && (rx_count_r != 8'h00) && (gap_bits_r == GAP_BITS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_valid_r <= 1'b0;
			frame_bcast_r <= 1'b0;
		end else begin
			frame_valid_r <= 1'b0;
			frame_bcast_r <= 1'b0;
			// a frame is acted on only with clean characters, zero crc residue and good format
			if (frame_end && !frame_err_r && crc_r == 16'h0000 && rx_count_r >= MIN_BYTES
			    && req_format_ok) begin
				if (rx_addr_r == BCAST_ADDR) begin
					frame_valid_r <= 1'b1;
					frame_bcast_r <= 1'b1;
				end else if (rx_addr_r == cfg_r.station) begin
					frame_valid_r <= 1'b1;
				end
			end
		end
	end

	// reply sequencer: nonvolatile write first, then a fresh whole-ms delay count
	assign reply_go = frame_valid_r & ~frame_bcast_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rp_st_r  <= RP_IDLE;
			rp_cyc_r <= '0;
			rp_ms_r  <= 5'h0;
		end else begin
			case (rp_st_r)
				RP_IDLE: if (reply_go && !tx_open_r) rp_st_r <= RP_NVM;
				RP_NVM: if (!nvm_busy) begin
					rp_st_r  <= RP_DELAY;
					rp_cyc_r <= '0;
					rp_ms_r  <= 5'h0;
				end
				RP_DELAY: if (rp_cyc_r == MS_LAST) begin
					rp_cyc_r <= '0;
					rp_ms_r  <= rp_ms_r + 1'b1;
					if (rp_ms_r + 1'b1 == cfg_r.delay) rp_st_r <= RP_IDLE;
				end else begin
					rp_cyc_r <= rp_cyc_r + 1'b1;
				end
				default: rp_st_r <= RP_IDLE;
			endcase
		end
	end

	// free-running millisecond tick for the timeout and the leader period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_r <= '0;
		end else begin
			ms_cnt_r <= (ms_cnt_r == MS_LAST) ? '0 : ms_cnt_r + 1'b1;
		end
	end
	assign ms_tick = (ms_cnt_r == MS_LAST);

	// timeout monitor in tenths of a second; a valid frame restarts it, expiry wins a tie
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			to_ms_r     <= 7'h0;
			to_tenths_r <= 16'h0000;
			fault_r     <= 1'b0;
		end else if (cfg_r.tmo == 16'h0000) begin
			to_ms_r     <= 7'h0;
			to_tenths_r <= 16'h0000;
			fault_r     <= 1'b0;
		end else begin
			if (frame_valid_r) begin
				to_ms_r     <= 7'h0;
				to_tenths_r <= 16'h0000;
			end else if (ms_tick) begin
				if (to_ms_r == 7'(MS_PER_TENTH - 1)) begin
					to_ms_r <= 7'h0;
					if (to_tenths_r != cfg_r.tmo) to_tenths_r <= to_tenths_r + 1'b1;
				end else begin
					to_ms_r <= to_ms_r + 1'b1;
				end
			end
			if (to_tenths_r == cfg_r.tmo) fault_r <= 1'b1;
			else if (frame_valid_r) fault_r <= 1'b0;
		end
	end

	// leader: periodic send request; a period of zero sends on every ms tick
	assign leader_go = cfg_r.peer_en & cfg_r.leader & ms_tick & (per_ms_r >= cfg_r.period);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_ms_r   <= 16'h0000;
			peer_req_r <= 1'b0;
		end else begin
			peer_req_r <= 1'b0;
			if (!(cfg_r.peer_en && cfg_r.leader)) begin
				per_ms_r <= 16'h0000;
			end else if (leader_go) begin
				per_ms_r   <= 16'h0001;
				peer_req_r <= ~tx_open_r;
			end else if (ms_tick) begin
				per_ms_r <= per_ms_r + 1'b1;
			end
		end
	end

	// follower: applied value is received value times scale in hundredths, saturated
	assign prod = peer_rx_value * cfg_r.scale;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			applied_r <= 16'h0000;
		end else if (peer_rx_stb && cfg_r.peer_en && !cfg_r.leader) begin
			applied_r <= ((prod / SCALE_UNITY) > 32'h0000_FFFF) ? 16'hFFFF
			             : 16'((prod / SCALE_UNITY));
		end
	end

	// transmit window: opened by reply timing or a leader send, closed by the last byte
	assign tx_take = tx_valid & tx_ready_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_open_r  <= 1'b0;
			tx_ready_r <= 1'b0;
			tx_last_r  <= 1'b0;
		end else begin
			if (rp_st_r == RP_DELAY && rp_cyc_r == MS_LAST && rp_ms_r + 1'b1 == cfg_r.delay)
				tx_open_r <= 1'b1;
			else if (peer_req_r)
				tx_open_r <= 1'b1;
			else if (tx_last_r && tx_st_r == TX_IDLE)
				tx_open_r <= 1'b0;
			if (tx_take) tx_last_r <= tx_last;
			else if (!tx_open_r) tx_last_r <= 1'b0;
			tx_ready_r <= tx_open_r & ~tx_last_r & (tx_st_r == TX_IDLE) & ~tx_take;
		end
	end

	// transmitter: start, eight data bits lsb first, optional parity, one or two stops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_r    <= TX_IDLE;
			tx_cnt_r   <= '0;
			tx_bit_r   <= 3'h0;
			tx_sh_r    <= 8'h00;
			tx_stop2_r <= 1'b0;
			txd_r      <= 1'b1;
		end else begin
			if (tx_cnt_r != '0) tx_cnt_r <= tx_cnt_r - 1'b1;
			case (tx_st_r)
				TX_IDLE: begin
					txd_r <= 1'b1;
					if (tx_take) begin
						tx_st_r  <= TX_START;
						tx_sh_r  <= tx_data;
						tx_cnt_r <= div - 1'b1;
						txd_r    <= 1'b0;
					end
				end
				TX_START: if (tx_cnt_r == '0) begin
					tx_st_r  <= TX_DATA;
					tx_bit_r <= 3'h0;
					tx_cnt_r <= div - 1'b1;
					txd_r    <= tx_sh_r[0];
				end
				TX_DATA: if (tx_cnt_r == '0) begin
					tx_cnt_r <= div - 1'b1;
					tx_bit_r <= tx_bit_r + 1'b1;
					if (tx_bit_r != LAST_BIT) begin
						txd_r <= tx_sh_r[3'(tx_bit_r + 1'b1)];
					end else if (par_kind(cfg_r.fmt) != 2'h0) begin
						tx_st_r <= TX_PAR;
						txd_r   <= par_bit(cfg_r.fmt, tx_sh_r);
					end else begin
						tx_st_r    <= TX_STOP;
						tx_stop2_r <= (cfg_r.fmt >= FMT_TWO_STOP);
						txd_r      <= 1'b1;
					end
				end
				TX_PAR: if (tx_cnt_r == '0) begin
					tx_st_r    <= TX_STOP;
					tx_cnt_r   <= div - 1'b1;
					tx_stop2_r <= (cfg_r.fmt >= FMT_TWO_STOP);
					txd_r      <= 1'b1;
				end
				TX_STOP: if (tx_cnt_r == '0) begin
					tx_cnt_r   <= div - 1'b1;
					tx_stop2_r <= 1'b0;
					if (!tx_stop2_r) tx_st_r <= TX_IDLE;
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) tx_drive_r <= 1'b0;
		else tx_drive_r <= tx_open_r | (tx_st_r != TX_IDLE);
	end

	assign prdata        = prdata_r;
	assign pready        = pready_r;
	assign pslverr       = pslverr_r;
	assign txd           = txd_r;
	assign tx_drive      = tx_drive_r;
	assign rx_byte       = rx_byte_r;
	assign rx_byte_stb   = rx_stb_r;
	assign frame_valid   = frame_valid_r;
	assign frame_bcast   = frame_bcast_r;
	assign tx_ready      = tx_ready_r;
	assign peer_send_req = peer_req_r;
	assign peer_var_sel  = cfg_r.var_sel;
	assign peer_applied  = applied_r;
	assign comm_fault    = fault_r;
endmodule : mrsl_top

// ### tb/mrsl_chk.sv
// port-level assertions for the modbus rtu station link
`timescale 1ns/1ps
module mrsl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txd,
	input wire logic tx_drive,
	input wire logic tx_ready,
	input wire logic frame_valid,
	input wire logic frame_bcast,
	input wire logic rx_byte_stb
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_answer_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	bcast_flag_a: assert property (frame_bcast |-> frame_valid)
		else $error("broadcast flag without frame");
	valid_pulse_a: assert property (frame_valid |=> !frame_valid)
		else $error("frame pulse too long");
	reply_wait_a: assert property (frame_valid && !tx_drive |=> !tx_drive [*8])
		else $error("reply started without delay");
	tx_idle_a: assert property (!tx_drive |-> txd)
		else $error("line not idle high");
	start_bit_a: assert property ($fell(txd) |-> !txd [*8])
		else $error("start bit too short");
	ready_window_a: assert property (tx_ready |-> tx_drive)
		else $error("tx ready outside window");
	byte_pulse_a: assert property (rx_byte_stb |=> !rx_byte_stb)
		else $error("byte strobe held too long");
endmodule : mrsl_chk
bind mrsl_top mrsl_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .txd,
	.tx_drive, .tx_ready, .frame_valid, .frame_bcast, .rx_byte_stb);

// ### tb/mrsl_master_model.sv
// bus master model: sends rtu request frames on the receive line
`timescale 1ns/1ps
module mrsl_master_model import mrsl_pkg::*; #(
	parameter int BIT_CYC = 21
)(
	input  wire logic       pclk,
	input  wire logic [2:0] fmt,
	output logic            rxd
);
	// biased bus idles high between frames
	initial rxd = 1'b1;
	// last character put on the line, for the bench to compare
	logic [7:0] last_b;
	// same rate and format as the station is up to the caller
	task automatic put(input logic [7:0] b);
		logic [11:0] w;
		int          n;
		w = (fmt % 3 == 0) ? {3'b111, b, 1'b0} : {2'b11, (fmt % 3 == 2) ? ~^b : ^b, b, 1'b0};
		n = 10 + int'(fmt % 3 != 0) + int'(fmt >= 3);
		last_b = b;
		for (int i = 0; i < n; i++)
			repeat (BIT_CYC) @(posedge pclk) rxd <= w[i];
	endtask : put
	task automatic send(input logic [7:0] a, input bit bad);
		logic [7:0]  f [4];
		logic [15:0] c;
		f = '{a, 8'h06, 8'h00, 8'h01};
		c = CRC_INIT;
		for (int k = 0; k < 4; k++) begin
			c = c ^ {8'h00, f[k]};
			for (int j = 0; j < 8; j++)
				c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		// a flipped check bit stands for line noise
		if (bad)
			c = c ^ 16'h0001;
		for (int k = 0; k < 4; k++)
			put(f[k]);
		put(c[7:0]);
		put(c[15:8]);
	endtask : send
endmodule : mrsl_master_model

// ### tb/test_mrsl_top.sv
// self-checking bench for the modbus rtu station link
`timescale 1ns/1ps
module test_mrsl_top import mrsl_pkg::*;;
	localparam int BIT = 21;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic        nvm_busy = 0, tx_valid = 0, tx_last = 0, peer_rx_stb = 0, req_format_ok = 1;
	logic        pready, pslverr, rxd, txd, tx_drive, rx_byte_stb, frame_valid, frame_bcast;
	logic        tx_ready, peer_send_req, comm_fault;
	logic [7:0]  paddr = 8'h00, tx_data = 8'h00, rx_byte;
	logic [2:0]  fmt = 3'h0, peer_var_sel;
	logic [15:0] peer_rx_value = 16'h0000, peer_applied;
	logic [31:0] pwdata = 32'h0, prdata, q;
	int          err_total = 0, cmp_count = 0;
	mrsl_top #(.CLK_HZ(2_500_000), .MS_CYCLES(50)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .tx_drive, .rx_byte,
		.rx_byte_stb, .frame_valid, .frame_bcast, .req_format_ok, .nvm_busy, .tx_data,
		.tx_valid, .tx_last, .tx_ready, .peer_send_req, .peer_var_sel, .peer_rx_value,
		.peer_rx_stb, .peer_applied, .comm_fault);
	mrsl_master_model #(.BIT_CYC(BIT)) mm (.pclk, .fmt, .rxd);
	initial forever #20 pclk = ~pclk;
	task automatic final_report();
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			$display("[FAIL] %s exp %h got %h", n, x, g);
			err_total++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_total++;
			final_report();
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0000, d});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] x, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, {16'h0000, x}, q);
	endtask : rd
	function automatic logic sig(input int k);
		return k == 0 ? frame_valid : k == 1 ? tx_drive : k == 2 ? comm_fault : k == 3 ? peer_send_req : tx_ready;
	endfunction : sig
	// must marks waits whose running out is a hang rather than the expected silence
	task automatic await(input int k, input int lim, input bit must, output int n);
		n = 0;
		while (sig(k) !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
		if (must && n >= lim) begin
			err_total++;
			final_report();
		end
	endtask : await
	task automatic s_regs();
		logic [15:0] r [10];
		r = '{RST_STATION, RST_BAUD, RST_FMT, RST_TMO, RST_DELAY, 16'h0000, 16'h0000, RST_VAR,
			RST_SCALE, RST_PERIOD};
		for (int i = 0; i < 10; i++)
			rd(8'(i * 4), r[i], "reset");
		rd(8'h2C, 16'h0000, "unmapped");
		chk("unmapped err", 1, e);
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_BAUD, 16'(i));
			rd(ADDR_BAUD, 16'(i), "baud");
			wr(ADDR_FMT, 16'(i));
			rd(ADDR_FMT, 16'(i), "fmt");
		end
		wr(ADDR_BAUD, 16'h0006);
		rd(ADDR_BAUD, 16'h0005, "baud max");
	endtask : s_regs
	task automatic s_reply();
		logic [10:0] s;
		int          n;
		wr(ADDR_STATION, 16'h0005);
		wr(ADDR_STATION, 16'h00F8);
		rd(ADDR_STATION, 16'h0005, "station");
		wr(ADDR_DELAY, 16'h0001);
		wr(ADDR_DELAY, 16'h0000);
		rd(ADDR_DELAY, 16'h0001, "delay");
		wr(ADDR_FMT, 16'h0002);
		fmt <= 3'h2;
		// let the model see the new format before its first character
		@(posedge pclk);
		mm.send(8'h06, 0);
		await(0, 1500, 0, n);
		chk("foreign", 1500, n);
		mm.send(8'h05, 1);
		await(0, 1500, 0, n);
		chk("bad crc", 1500, n);
		req_format_ok <= 1'b0;
		mm.send(8'h05, 0);
		await(0, 1500, 0, n);
		chk("bad format", 1500, n);
		req_format_ok <= 1'b1;
		nvm_busy <= 1'b1;
		mm.send(8'h05, 0);
		await(0, 1500, 1, n);
		chk("own bcast", 0, frame_bcast);
		chk("rx byte", mm.last_b, rx_byte);
		repeat (200) @(posedge pclk);
		chk("nvm wait", 0, tx_drive);
		nvm_busy <= 1'b0;
		repeat (45) @(posedge pclk);
		chk("delay wait", 0, tx_drive);
		await(1, 10, 0, n);
		chk("reply open", 1, n < 10);
		await(4, 20, 1, n);
		tx_data <= 8'hA5;
		tx_valid <= 1'b1;
		tx_last <= 1'b1;
		@(posedge pclk);
		tx_valid <= 1'b0;
		tx_last <= 1'b0;
		repeat (1 + BIT / 2) @(posedge pclk);
		for (int i = 0; i < 11; i++) begin
			s[i] = txd;
			repeat (BIT) @(posedge pclk);
		end
		chk("tx char", {1'b1, ~^8'hA5, 8'hA5, 1'b0}, s);
	endtask : s_reply
	task automatic s_bcast();
		int n;
		wr(ADDR_TMO, 16'h0001);
		mm.send(8'h00, 0);
		await(0, 1500, 1, n);
		chk("bcast", 1, frame_bcast);
		repeat (4800) @(posedge pclk);
		chk("no reply", 0, tx_drive);
		chk("early fault", 0, comm_fault);
		await(2, 600, 0, n);
		chk("fault", 1, n < 600);
		rd(ADDR_STATUS, 16'h0001, "status");
		wr(ADDR_TMO, 16'h0000);
		repeat (3) @(posedge pclk);
		chk("fault off", 0, comm_fault);
	endtask : s_bcast
	task automatic s_peer();
		int n;
		wr(ADDR_PEER_EN, 16'h0001);
		wr(ADDR_SCALE, 16'h0050);
		@(posedge pclk);
		peer_rx_value <= 16'h03E8;
		peer_rx_stb <= 1'b1;
		@(posedge pclk);
		peer_rx_stb <= 1'b0;
		@(posedge pclk);
		chk("applied", 16'h0320, peer_applied);
		wr(ADDR_SCALE, 16'h03E9);
		rd(ADDR_SCALE, 16'h0050, "scale");
		wr(ADDR_VAR, 16'h0003);
		wr(ADDR_PERIOD, 16'h0002);
		wr(ADDR_ROLE, 16'h0001);
		await(3, 300, 0, n);
		chk("leader send", 1, n < 300);
		chk("leader var", 3, peer_var_sel);
	endtask : s_peer
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		s_regs();
		s_reply();
		s_bcast();
		s_peer();
		final_report();
	end
endmodule : test_mrsl_top
